// ---- verilog/sdwmr_pkg.sv ----
// sdwmr_pkg: constants shared by the dram end and the controller end.
// assumes one clock MCLK at 100 MHz on both ends of the link.
package sdwmr_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int TCK_PS = 10000;
  localparam int T_RFC_PS = 160000;
  localparam int T_REFI_PS = 7800000;
  localparam int T_WTR_PS = 7500;
  localparam int T_WR_PS = 15000;
  localparam int T_RP_PS = 13750;
  localparam int N_RFC = (T_RFC_PS + TCK_PS - 1) / TCK_PS;
  localparam int N_WTR = (T_WTR_PS + TCK_PS - 1) / TCK_PS;
  localparam int N_WR = (T_WR_PS + TCK_PS - 1) / TCK_PS;
  localparam int N_RP = (T_RP_PS + TCK_PS - 1) / TCK_PS;
  localparam int N_REFI = T_REFI_PS / TCK_PS;
  localparam int ADD_LAT = 0;
  localparam int COL_WR_LAT = 5;
  localparam int WR_LAT = ADD_LAT + COL_WR_LAT;
  localparam int RD_LAT = 6;
  localparam int CNT_W = 10;
  // ----------------------------------------------------------------
  // link widths and fields
  // ----------------------------------------------------------------
  localparam int DQ_W = 8;
  localparam int MASK_W = DQ_W / 8;
  localparam int ADDR_W = 14;
  localparam int BA_W = 3;
  localparam int NBANK = 8;
  localparam int BURST_LSB = 0;
  localparam int TERM_STROBE_BIT = 11;
  localparam int BURST_SEL_BIT = 12;
  localparam int PRE_ALL_BIT = 10;
  localparam logic [1:0] BF_EIGHT = 2'h0;
  localparam logic [1:0] BF_OTF = 2'h1;
  localparam logic [1:0] BF_CHOP = 2'h2;
  localparam logic [3:0] BEATS_EIGHT = 4'h8;
  localparam logic [3:0] BEATS_CHOP = 4'h4;
  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_IDLE = 4'h7;
  // ----------------------------------------------------------------
  // controller registers
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_WDATA_LO = 8'h08;
  localparam logic [7:0] REG_WDATA_HI = 8'h0C;
  localparam logic [7:0] REG_WMASK = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_RDATA = 8'h18;
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_ACT = 3'h1;
  localparam logic [2:0] OP_WR = 3'h2;
  localparam logic [2:0] OP_RD = 3'h3;
  localparam logic [2:0] OP_PRE = 3'h4;
  localparam logic [2:0] OP_REF = 3'h5;
  localparam logic [2:0] OP_MRS = 3'h6;
  localparam logic [2:0] OP_SREF = 3'h7;
  localparam logic signed [4:0] DEBT_MAX = 5'sd8;
  localparam logic signed [4:0] DEBT_MIN = -5'sd8;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;

  // beats of a burst from the burst field and the burst-select bit
  function automatic logic [3:0] burst_beats(input logic [1:0] field, input logic sel);
    if (field == BF_CHOP) return BEATS_CHOP;
    if (field == BF_OTF && !sel) return BEATS_CHOP;
    return BEATS_EIGHT;
  endfunction
endpackage

// ---- verilog/sdwmr_link_if.sv ----
// sdwmr_link_if: command, address and write data link between the ends.
// assumes both ends run on MCLK; one data beat per clock.
`timescale 1ns/1ps
interface sdwmr_link_if (
  input wire logic MCLK
);
  import sdwmr_pkg::*;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] dq;
  logic [MASK_W-1:0] write_byte_mask;
  logic [DQ_W-1:0] rdq;
  logic rdq_valid;
  modport ctrl_end (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq, write_byte_mask,
    input rdq, rdq_valid);
  modport dram_end (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq, write_byte_mask,
    output rdq, rdq_valid);
endinterface

// ---- verilog/sdwmr_dram.sv ----
// sdwmr_dram: device end; decodes commands, captures masked write beats,
// runs refresh from its own row counter. assumes a well behaved controller.
`timescale 1ns/1ps
module sdwmr_dram
  import sdwmr_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // link
  sdwmr_link_if.dram_end LINK,
  // memory write port
  output logic MEM_WE,
  output logic [BA_W-1:0] MEM_BANK,
  output logic [3:0] MEM_BEAT,
  output logic [DQ_W-1:0] MEM_WDATA,
  output logic TERM_STROBE,
  // read data source
  input wire logic [DQ_W-1:0] RD_DATA,
  // state
  output logic [ADDR_W-1:0] REF_ROW,
  output logic REF_BUSY,
  output logic [NBANK-1:0] BANK_OPEN
);
  import sdwmr_pkg::*;
  logic [ADDR_W-1:0] mode_register_zero;
  logic [ADDR_W-1:0] mode_register_one;
  logic [3:0] wdelay, wrem, rdelay, rrem, beat;
  logic [BA_W-1:0] wbank;
  logic [CNT_W-1:0] rfc_cnt;
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [3:0] cmd = {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n};
  wire live = LINK.cke;
  wire is_ref = live && cmd == CMD_REF; // RQ8
  wire is_wr = live && cmd == CMD_WR;
  wire is_rd = live && cmd == CMD_RD;
  wire is_pre = live && cmd == CMD_PRE;
  wire is_act = live && cmd == CMD_ACT;
  wire is_mrs = live && cmd == CMD_MRS;
  wire [3:0] beats = burst_beats(mode_register_zero[BURST_LSB +: 2], LINK.addr[BURST_SEL_BIT]); // RQ4 RQ5 RQ20
  wire term_mode = mode_register_one[TERM_STROBE_BIT];
  wire wbeat = wdelay == 4'h0 && wrem != 4'h0;
  wire rbeat = rdelay == 4'h0 && rrem != 4'h0;
  wire masked = LINK.write_byte_mask[0] && !term_mode; // RQ1 RQ3
  // ----------------------------------------------------------------
  // mode registers and banks
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      mode_register_zero <= '0;
      mode_register_one <= '0;
      BANK_OPEN <= '0;
    end else begin
      if (is_mrs && LINK.ba == 3'h0) mode_register_zero <= LINK.addr;
      if (is_mrs && LINK.ba == 3'h1) mode_register_one <= LINK.addr;
      if (is_act) BANK_OPEN[LINK.ba] <= 1'b1;
      if (is_pre && LINK.addr[PRE_ALL_BIT]) BANK_OPEN <= '0;
      else if (is_pre) BANK_OPEN[LINK.ba] <= 1'b0;
      if (REF_BUSY && rfc_cnt == 10'h001) BANK_OPEN <= '0; // RQ12
    end
  end
  // ----------------------------------------------------------------
  // write and read bursts
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      wdelay <= '0;
      wrem <= '0;
      rdelay <= '0;
      rrem <= '0;
      beat <= '0;
      wbank <= '0;
    end else begin
      if (is_wr) begin
        wdelay <= 4'(WR_LAT - 1); // RQ22
        wrem <= beats;
        wbank <= LINK.ba;
        beat <= '0;
      end else if (wdelay != 4'h0) wdelay <= wdelay - 4'h1;
      else if (wrem != 4'h0) begin
        wrem <= wrem - 4'h1;
        beat <= beat + 4'h1;
      end
      if (is_rd) begin
        rdelay <= 4'(RD_LAT - 1);
        rrem <= beats;
      end else if (rdelay != 4'h0) rdelay <= rdelay - 4'h1;
      else if (rrem != 4'h0) rrem <= rrem - 4'h1;
    end
  end
  // mask and data sampled on the same edge; no write during reads
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      MEM_WE <= 1'b0;
      MEM_BANK <= '0;
      MEM_BEAT <= '0;
      MEM_WDATA <= '0;
      TERM_STROBE <= 1'b0;
      LINK.rdq <= '0;
      LINK.rdq_valid <= 1'b0;
    end else begin
      MEM_WE <= wbeat && !masked; // RQ1 RQ2
      MEM_BANK <= wbank;
      MEM_BEAT <= beat;
      MEM_WDATA <= LINK.dq;
      TERM_STROBE <= wbeat && term_mode; // RQ3
      LINK.rdq <= RD_DATA;
      LINK.rdq_valid <= rbeat;
    end
  end
  // ----------------------------------------------------------------
  // refresh
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      REF_ROW <= '0;
      REF_BUSY <= 1'b0;
      rfc_cnt <= '0;
    end else if (is_ref && !REF_BUSY) begin
      REF_ROW <= REF_ROW + 14'h0001; // RQ11
      REF_BUSY <= 1'b1;
      rfc_cnt <= CNT_W'(N_RFC);
    end else if (rfc_cnt != '0) begin
      rfc_cnt <= rfc_cnt - 10'h001;
      if (rfc_cnt == 10'h001) REF_BUSY <= 1'b0;
    end
  end
endmodule // sdwmr_dram

// ---- verilog/sdwmr_ctrl.sv ----
// sdwmr_ctrl: controller end; takes orders over apb, drives the link,
// keeps write/refresh spacing and the refresh debt. assumes one clock.
`timescale 1ns/1ps
// Operation
// RQ1: one mask bit per eight data lines
// RQ2: mask sampled like data, ignored on reads
// RQ3: option bit turns mask into termination strobe
// RQ4: eight beats for field 00, or 01 selected
// RQ5: field 10 chops every burst to four
// RQ6: read waits write-to-read time after last beat
// RQ7: precharge waits write recovery after last beat; only ordered precharges wait, the precharge-all before a refresh does not
// RQ8: refresh is cs, ras, cas low, we high
// RQ9: one command issued for every refresh
// RQ10: all banks precharged and rested before refresh
// RQ11: refresh rows come from internal counter
// RQ12: refresh leaves all banks precharged
// RQ13: only no-operation commands during refresh cycle
// RQ14: refresh on average every refresh interval
// RQ15: at most eight refreshes postponed
// RQ16: at most eight refreshes pulled in
// RQ17: at most sixteen refreshes per two intervals
// RQ18: self-refresh entry with at most eight postponed
// RQ19: debt frozen during self-refresh
// RQ20: burst-select bit low chops, high gives eight
// RQ21: signed debt counter clamped to plus/minus eight
// RQ22: first beat at additive plus column latency
module sdwmr_ctrl
  import sdwmr_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // link
  sdwmr_link_if.ctrl_end LINK
);
  import sdwmr_pkg::*;
  typedef enum logic [1:0] {
    SC_RUN = 2'b00,
    SC_SREF = 2'b01
  } sdwmr_state_t;
  sdwmr_state_t state;
  logic [31:0] ctrl_reg, wdata_lo, wdata_hi, wmask, rdata;
  logic pend;
  logic [2:0] pend_op;
  logic [BA_W-1:0] pend_ba;
  logic [ADDR_W-1:0] pend_addr;
  logic [1:0] burst_field;
  logic term_mode;
  logic [NBANK-1:0] bank_open;
  logic [CNT_W-1:0] gap_cnt, refi_cnt, wtr_cnt, wr_cnt;
  logic [3:0] wdelay, wrem;
  logic last_beat;
  logic [63:0] wshift;
  logic [7:0] mshift;
  logic signed [4:0] debt;
  logic signed [4:0] next_debt;
  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire access = PSEL && PENABLE;
  wire hit_cmd = PADDR == REG_CMD;
  wire mapped = PADDR == REG_CTRL || hit_cmd || PADDR == REG_WDATA_LO || PADDR == REG_WDATA_HI
    || PADDR == REG_WMASK || PADDR == REG_STATUS || PADDR == REG_RDATA;
  wire cmd_stall = PWRITE && hit_cmd && pend;
  wire wr_take = access && PWRITE && PREADY;
  wire [31:0] status = {23'h0, debt, bank_open != '0, state == SC_SREF, gap_cnt != '0, pend};
  assign PREADY = !cmd_stall;
  assign PSLVERR = access && !mapped;
  wire [31:0] rd_mux = !mapped ? 32'h0 : PADDR == REG_CTRL ? ctrl_reg : PADDR == REG_WDATA_LO ? wdata_lo
    : PADDR == REG_WDATA_HI ? wdata_hi : PADDR == REG_WMASK ? wmask : PADDR == REG_STATUS ? status
    : PADDR == REG_RDATA ? rdata : 32'h0;
  // ----------------------------------------------------------------
  // scheduling
  // ----------------------------------------------------------------
  wire tick = refi_cnt == 10'(N_REFI - 1);
  wire burst_busy = wdelay != 4'h0 || wrem != 4'h0 || last_beat;
  wire free = gap_cnt == '0 && !burst_busy && state == SC_RUN; // RQ13
  wire banks_shut = bank_open == '0;
  wire must_ref = debt >= DEBT_MAX; // RQ15
  wire want_ref = must_ref || (pend && pend_op == OP_REF) || (ctrl_reg[0] && debt > 5'sd0 && !pend); // RQ14
  wire can_pull = debt > DEBT_MIN; // RQ16 RQ17
  wire go_ref = free && want_ref && banks_shut && (can_pull || must_ref); // RQ10
  wire go_prea = free && want_ref && !banks_shut;
  wire cmd_ok = pend_op == OP_RD ? wtr_cnt == '0 : pend_op == OP_PRE ? wr_cnt == '0 // RQ6 RQ7
    : pend_op == OP_SREF ? banks_shut : 1'b1;
  wire go_cmd = free && !want_ref && pend && cmd_ok;
  wire ref_drop = free && pend && pend_op == OP_REF && !can_pull;
  wire go_srx = state == SC_SREF && pend && pend_op == OP_SREF;
  wire [3:0] beats = burst_beats(burst_field, pend_addr[BURST_SEL_BIT]); // RQ4 RQ5 RQ20
  wire ref_dec = go_ref || (go_cmd && pend_op == OP_SREF);
  always_comb begin
    next_debt = debt;
    if (state == SC_RUN && tick && !ref_dec && debt < DEBT_MAX) next_debt = debt + 5'sd1; // RQ21
    else if (state == SC_RUN && ref_dec && !tick && debt > DEBT_MIN) next_debt = debt - 5'sd1; // RQ21
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= CTRL_RESET;
      PRDATA <= '0;
      wdata_lo <= '0;
      wdata_hi <= '0;
      wmask <= '0;
      pend <= 1'b0;
      pend_op <= OP_NONE;
      pend_ba <= '0;
      pend_addr <= '0;
    end else begin
      if (PSEL && !PENABLE) PRDATA <= rd_mux;
      if (wr_take && PADDR == REG_CTRL) ctrl_reg <= {31'h0, PWDATA[0]};
      if (wr_take && PADDR == REG_WDATA_LO) wdata_lo <= PWDATA;
      if (wr_take && PADDR == REG_WDATA_HI) wdata_hi <= PWDATA;
      if (wr_take && PADDR == REG_WMASK) wmask <= {24'h0, PWDATA[7:0]};
      if (wr_take && hit_cmd && PWDATA[2:0] != OP_NONE) begin
        pend <= 1'b1;
        pend_op <= PWDATA[2:0];
        pend_ba <= PWDATA[5:3];
        pend_addr <= PWDATA[19:6];
      end else if (go_cmd || go_srx || ref_drop || (go_ref && pend && pend_op == OP_REF)) pend <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // command issue
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state <= SC_RUN;
      {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} <= CMD_IDLE;
      LINK.cke <= 1'b1;
      LINK.ba <= '0;
      LINK.addr <= '0;
      bank_open <= '0;
      burst_field <= BF_EIGHT;
      term_mode <= 1'b0;
      gap_cnt <= '0;
      debt <= '0;
      refi_cnt <= '0;
    end else begin
      {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} <= CMD_IDLE;
      debt <= next_debt;
      if (state == SC_RUN) refi_cnt <= tick ? '0 : refi_cnt + 10'h001; // RQ19
      if (gap_cnt != '0) gap_cnt <= gap_cnt - 10'h001;
      if (go_srx) begin
        state <= SC_RUN;
        LINK.cke <= 1'b1;
      end else if (go_prea) begin
        {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} <= CMD_PRE;
        LINK.addr <= ADDR_W'(1) << PRE_ALL_BIT;
        bank_open <= '0;
        gap_cnt <= CNT_W'(N_RP); // RQ10
      end else if (go_ref) begin
        {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} <= CMD_REF; // RQ8 RQ9
        gap_cnt <= CNT_W'(N_RFC); // RQ13
      end else if (go_cmd) begin
        LINK.ba <= pend_ba;
        LINK.addr <= pend_addr;
        case (pend_op)
          OP_ACT: begin
            {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} <= CMD_ACT;
            bank_open[pend_ba] <= 1'b1;
          end
          OP_WR: {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} <= CMD_WR;
          OP_RD: {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} <= CMD_RD;
          OP_PRE: begin
            {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} <= CMD_PRE;
            if (pend_addr[PRE_ALL_BIT]) bank_open <= '0;
            else bank_open[pend_ba] <= 1'b0;
            gap_cnt <= CNT_W'(N_RP);
          end
          OP_MRS: begin
            {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} <= CMD_MRS;
            if (pend_ba == 3'h0) burst_field <= pend_addr[BURST_LSB +: 2];
            if (pend_ba == 3'h1) term_mode <= pend_addr[TERM_STROBE_BIT];
          end
          OP_SREF: begin
            {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} <= CMD_REF; // RQ18
            LINK.cke <= 1'b0;
            state <= SC_SREF;
          end
          default: {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} <= CMD_IDLE;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // write beats and recovery counters
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      wdelay <= '0;
      wrem <= '0;
      last_beat <= 1'b0;
      wshift <= '0;
      mshift <= '0;
      LINK.dq <= '0;
      LINK.write_byte_mask <= '0;
      wtr_cnt <= '0;
      wr_cnt <= '0;
    end else begin
      last_beat <= 1'b0;
      if (wtr_cnt != '0) wtr_cnt <= wtr_cnt - 10'h001;
      if (wr_cnt != '0) wr_cnt <= wr_cnt - 10'h001;
      if (go_cmd && pend_op == OP_WR) begin
        wdelay <= 4'(WR_LAT - 1); // RQ22
        wrem <= beats;
        wshift <= {wdata_hi, wdata_lo};
        mshift <= wmask[7:0];
      end else if (wdelay != 4'h0) wdelay <= wdelay - 4'h1;
      else if (wrem != 4'h0) begin
        LINK.dq <= wshift[DQ_W-1:0];
        LINK.write_byte_mask <= term_mode ? 1'b0 : mshift[0]; // RQ1 RQ2 RQ3
        wshift <= wshift >> DQ_W;
        mshift <= mshift >> 1;
        wrem <= wrem - 4'h1;
        last_beat <= wrem == 4'h1;
      end else LINK.write_byte_mask <= 1'b0;
      if (last_beat) begin
        wtr_cnt <= CNT_W'(N_WTR); // RQ6
        wr_cnt <= CNT_W'(N_WR); // RQ7
      end
    end
  end
  // read beats collected into the read data register
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) rdata <= '0;
    else if (LINK.rdq_valid) rdata <= {rdata[23:0], LINK.rdq}; // RQ2
  end
endmodule // sdwmr_ctrl

// ---- tb/sdwmr_properties.sv ----
// sdwmr_properties: timing checks on the link between the two ends.
// assumes one clock MCLK and an active high asynchronous reset RST.
`timescale 1ns/1ps
module sdwmr_properties
  import sdwmr_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // link
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DQ_W-1:0] dq,
  input wire logic [MASK_W-1:0] write_byte_mask,
  input wire logic [DQ_W-1:0] rdq,
  input wire logic rdq_valid
);
  // ----------------------------------------------------------------
  // command decode and snooped state
  // ----------------------------------------------------------------
  logic [3:0] cmd;
  logic is_ref;
  logic is_rd;
  logic is_wr;
  logic is_pre;
  logic rd8;
  logic [1:0] bf;
  logic [4:0] lock;
  logic [4:0] next_lock;
  logic [NBANK-1:0] opn;
  logic [NBANK-1:0] next_opn;
  logic [NBANK-1:0] one_bank;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign is_ref = cke && cmd == CMD_REF;
  assign is_rd = cke && cmd == CMD_RD;
  assign is_wr = cke && cmd == CMD_WR;
  assign is_pre = cke && cmd == CMD_PRE;
  assign rd8 = bf == BF_EIGHT || (bf == BF_OTF && addr[BURST_SEL_BIT]);
  assign one_bank = NBANK'(1) << ba;
  assign next_lock = is_ref ? 5'(N_RFC - 1) : (lock != 5'h0 ? lock - 5'h1 : lock);
  assign next_opn = is_ref ? '0 : (cke && cmd == CMD_ACT) ? opn | one_bank
    : is_pre ? opn & ~(addr[PRE_ALL_BIT] ? {NBANK{1'b1}} : one_bank) : opn;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      lock <= 5'h0;
      opn <= '0;
    end else begin
      lock <= next_lock;
      opn <= next_opn;
    end
  end
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      bf <= BF_EIGHT;
    end else if (cke && cmd == CMD_MRS && ba == '0) begin
      bf <= addr[BURST_LSB +: 2];
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_chop;
    rdq_valid [*4] ##1 !rdq_valid;
  endsequence
  sequence s_eight;
    rdq_valid [*8] ##1 !rdq_valid;
  endsequence
  chk_ref_idle_hold: assert property (lock != 5'h0 |-> cmd == CMD_IDLE)
    else $error("command issued inside refresh lockout");
  chk_rd_chop_len: assert property (is_rd && !rd8 |-> ##1 (!rdq_valid) [*6] ##1 s_chop)
    else $error("chopped read burst length wrong");
  chk_rd_eight_len: assert property (is_rd && rd8 |-> ##1 (!rdq_valid) [*6] ##1 s_eight)
    else $error("eight beat read burst length wrong");
  chk_wr_rd_gap: assert property (is_wr |-> ##1 (cmd != CMD_RD) [*8])
    else $error("read too soon after write");
  chk_wr_pre_gap: assert property (is_wr |-> ##1 (cmd != CMD_PRE) [*8] ##1 cmd != CMD_PRE)
    else $error("precharge too soon after write");
  chk_ref_banks_shut: assert property (is_ref |-> opn == '0)
    else $error("refresh with a bank open");
  chk_ref_rp_rest: assert property (is_ref |-> $past(cmd) != CMD_PRE && $past(cmd, 2) != CMD_PRE)
    else $error("refresh inside precharge time");
  chk_ref_spacing: assert property (is_ref |=> (!is_ref) [*8])
    else $error("refresh commands packed too closely");
endmodule // sdwmr_properties

// ---- tb/tb_sdram_write_mask_and_refresh.sv ----
// tb_sdram_write_mask_and_refresh: controller and dram ends joined by the link.
// assumes software orders over apb; the dram end is watched at its memory port.
`timescale 1ns/1ps
module tb_sdram_write_mask_and_refresh;
  import sdwmr_pkg::*;
  logic mclk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic mem_we;
  logic [3:0] mem_beat;
  logic [BA_W-1:0] mem_bank;
  logic ref_busy;
  int busy_cnt = 0;
  logic [DQ_W-1:0] mem_wdata;
  logic term_strobe;
  logic [DQ_W-1:0] rd_data;
  logic [ADDR_W-1:0] ref_row;
  logic [ADDR_W-1:0] row0;
  logic [NBANK-1:0] bank_open;
  logic [31:0] rv;
  logic er;
  logic [4:0] debt0;
  logic [63:0] wdat = 64'hF0E1D2C3B4A59687;
  logic [1:0] fld [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
  logic sel [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic [7:0] msk [4] = '{8'h0A, 8'h00, 8'h82, 8'h00};
  int nb [4] = '{8, 4, 8, 4};
  int n_fail = 0;
  int comparisons = 0;
  int we_cnt = 0;
  int ts_cnt = 0;
  int cyc = 0;
  int wr_cyc = 0;
  int we_cyc = 0;
  sdwmr_link_if sdwmr_link_if_i (.MCLK(mclk));
  sdwmr_ctrl sdwmr_ctrl_i (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LINK(sdwmr_link_if_i));
  sdwmr_dram sdwmr_dram_i (.MCLK(mclk), .RST(rst), .LINK(sdwmr_link_if_i), .MEM_WE(mem_we),
    .MEM_BANK(mem_bank), .MEM_BEAT(mem_beat), .MEM_WDATA(mem_wdata), .TERM_STROBE(term_strobe),
    .RD_DATA(rd_data), .REF_ROW(ref_row), .REF_BUSY(ref_busy), .BANK_OPEN(bank_open));
  sdwmr_properties sdwmr_properties_i (.MCLK(mclk), .RST(rst), .cke(sdwmr_link_if_i.cke),
    .cs_n(sdwmr_link_if_i.cs_n), .ras_n(sdwmr_link_if_i.ras_n), .cas_n(sdwmr_link_if_i.cas_n),
    .we_n(sdwmr_link_if_i.we_n), .ba(sdwmr_link_if_i.ba), .addr(sdwmr_link_if_i.addr),
    .dq(sdwmr_link_if_i.dq), .write_byte_mask(sdwmr_link_if_i.write_byte_mask),
    .rdq(sdwmr_link_if_i.rdq), .rdq_valid(sdwmr_link_if_i.rdq_valid));
  // ----------------------------------------------------------------
  // clock, checks and bus tasks
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic print_verdict();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    print_verdict();
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 2000; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    rv = prdata;
    er = pslverr;
    if (n == 2000) hang();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic order(input logic [2:0] op, input logic [2:0] bk, input logic [13:0] ad);
    int n;
    apb(1'b1, REG_CMD, {12'h0, ad, bk, op});
    for (n = 0; n < 200; n++) begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (rv[1:0] === 2'b00) break;
    end
    if (n == 200) hang();
    repeat (16) @(posedge mclk);
  endtask
  function automatic int unmasked(input int beats, input logic [7:0] m);
    int c = 0;
    for (int k = 0; k < beats; k++) c += m[k] ? 0 : 1;
    return c;
  endfunction
  // memory port monitor
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (sdwmr_link_if_i.cke === 1'b1 && {sdwmr_link_if_i.cs_n, sdwmr_link_if_i.ras_n,
        sdwmr_link_if_i.cas_n, sdwmr_link_if_i.we_n} === CMD_WR) wr_cyc <= cyc;
    if (mem_we === 1'b1) begin
      if (we_cnt == 0) we_cyc <= cyc;
      we_cnt <= we_cnt + 1;
      chk("mem_beat", 32'(cyc - wr_cyc - WR_LAT - 1), 32'(mem_beat));
      chk("mem_bank", 32'h2, 32'(mem_bank));
      chk("mem_wdata", 32'(wdat[8*mem_beat +: 8]), 32'(mem_wdata));
    end
    if (term_strobe === 1'b1) ts_cnt <= ts_cnt + 1;
    if (ref_busy === 1'b1) busy_cnt <= busy_cnt + 1;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rd_data = 8'hA5;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", CTRL_RESET, rv);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", 32'h0, rv);
    chk("pslverr", 32'h1, 32'(er));
    // refreshes pulled in with a bank open; the ninth is dropped
    row0 = ref_row;
    order(OP_ACT, 3'h2, 14'h0);
    chk("bank_open", 32'h4, 32'(bank_open));
    for (int i = 0; i < 9; i++) order(OP_REF, 3'h0, 14'h3FFF);
    chk("ref_row", 32'(row0 + 14'h8), 32'(ref_row));
    chk("ref_busy", 32'(8 * N_RFC), 32'(busy_cnt));
    chk("bank_idle", 32'h0, 32'(bank_open));
    apb(1'b0, REG_STATUS, 32'h0);
    chk("debt_floor", 32'h18, 32'(rv[8:4]));
    debt0 = rv[8:4];
    // self-refresh keeps the debt
    order(OP_SREF, 3'h0, 14'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("sref_on", 32'h1, 32'(rv[2]));
    repeat (1700) @(posedge mclk);
    order(OP_SREF, 3'h0, 14'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("sref_debt", 32'(debt0), 32'(rv[8:4]));
    // write burst modes, each followed by a read
    apb(1'b1, REG_WDATA_LO, wdat[31:0]);
    apb(1'b1, REG_WDATA_HI, wdat[63:32]);
    order(OP_ACT, 3'h2, 14'h0);
    for (int i = 0; i < 4; i++) begin
      order(OP_MRS, 3'h0, {12'h0, fld[i]});
      apb(1'b1, REG_WMASK, {24'h0, msk[i]});
      we_cnt = 0;
      order(OP_WR, 3'h2, {1'b0, sel[i], 12'h0});
      chk("write_beats", 32'(unmasked(nb[i], msk[i])), 32'(we_cnt));
      chk("first_beat", 32'(WR_LAT + 1), 32'(we_cyc - wr_cyc));
      order(OP_RD, 3'h2, {1'b0, sel[i], 12'h0});
      chk("read_no_write", 32'(unmasked(nb[i], msk[i])), 32'(we_cnt));
    end
    apb(1'b0, REG_RDATA, 32'h0);
    chk("rdata", 32'hA5A5A5A5, rv);
    // mask pin used as termination strobe
    order(OP_MRS, 3'h1, 14'h0800);
    order(OP_MRS, 3'h0, 14'h0);
    apb(1'b1, REG_WMASK, 32'hFF);
    we_cnt = 0;
    ts_cnt = 0;
    order(OP_WR, 3'h2, 14'h1000);
    chk("strobe_beats", 32'h8, 32'(ts_cnt));
    chk("strobe_writes", 32'h8, 32'(we_cnt));
    order(OP_MRS, 3'h1, 14'h0);
    order(OP_PRE, 3'h2, 14'h0);
    chk("bank_closed", 32'h0, 32'(bank_open));
    print_verdict();
  end
endmodule // tb_sdram_write_mask_and_refresh
